// ==== include/sct_fill_pkg.sv ====
// Shared constants and types of the fill engine and host
package sct_fill_pkg;
  // ==========================================================
  // Key sector codes and layout
  localparam logic [15:0] ACT_WRITE_SAME = 16'h0002;
  localparam logic [15:0] FN_BG_PAT = 16'h0001;
  localparam logic [15:0] FN_BG_SEC = 16'h0002;
  localparam logic [15:0] FN_BLK_PAT = 16'h0101;
  localparam logic [15:0] FN_BLK_SEC = 16'h0102;
  localparam int FN_SEC_BIT = 1; // Set for host-supplied sector fills
  localparam int FN_BLK_BIT = 8; // Set for blocking fills
  localparam logic [3:0] KW_ACTION = 4'h0;
  localparam logic [3:0] KW_FUNC = 4'h1;
  localparam logic [3:0] KW_START = 4'h2; // Words 5:2
  localparam logic [3:0] KW_COUNT = 4'h6; // Words 9:6
  localparam logic [3:0] KW_PAT = 4'ha; // Words 11:10
  localparam logic [3:0] KW_LAST = 4'hb;
  localparam int SECTOR_WORDS = 128; // 32-bit words per sector
  localparam logic [6:0] SECTOR_LAST = 7'h7f;
  // ==========================================================
  // Task-file answers
  localparam logic [7:0] TF_ST_OK = 8'h50;
  localparam logic [7:0] TF_ST_ERR = 8'h51;
  localparam logic [7:0] TF_ERR_NONE = 8'h00;
  localparam logic [7:0] TF_ERR_ABRT = 8'h04;
  localparam logic [7:0] TF_XFER_LO = 8'h01;
  localparam logic [7:0] TF_XFER_HI = 8'h00;
  // ==========================================================
  // Extended status codes
  localparam logic [15:0] EXT_OK = 16'h0000;
  localparam logic [15:0] EXT_RUNNING = 16'hffff;
  localparam logic [15:0] EXT_BG_ABORT = 16'h0008;
  localparam logic [15:0] EXT_BG_UNREC = 16'h0009;
  localparam logic [15:0] EXT_BLK_UNREC = 16'h0017;
  localparam logic [15:0] EXT_BAD_FUNC = 16'h0004;
  localparam logic [15:0] EXT_BAD_RANGE = 16'h0005;
  localparam int FLAG_WHOLE_BIT = 0; // Whole-media-written flag
  // ==========================================================
  // Command kinds on the link
  typedef enum logic [1:0] {CMD_WRITE_SAME, CMD_SCT_STATUS, CMD_OTHER} cmd_kind_e;
  // ==========================================================
  // Host controller register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FUNC = 8'h04;
  localparam logic [7:0] REG_START_LO = 8'h08;
  localparam logic [7:0] REG_START_HI = 8'h0c;
  localparam logic [7:0] REG_COUNT_LO = 8'h10;
  localparam logic [7:0] REG_COUNT_HI = 8'h14;
  localparam logic [7:0] REG_PATTERN = 8'h18;
  localparam logic [7:0] REG_DATA = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_TF = 8'h24;
  localparam logic [7:0] REG_EXT = 8'h28;
  localparam logic [7:0] REG_LBA_LO = 8'h2c;
  localparam logic [7:0] REG_LBA_HI = 8'h30;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_KIND_LSB = 1;
endpackage

// ==== include/sct_link_if.sv ====
// Command link between host controller and fill engine
`timescale 1ns/1ps
interface sct_link_if
  import sct_fill_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn
);
  // Host to device
  logic cmd_valid;
  cmd_kind_e cmd_kind;
  logic key_valid;
  logic [15:0] key_word;
  logic data_valid;
  logic [31:0] data_word;
  // Device to host
  logic data_ready;
  logic done;
  logic [7:0] tf_error;
  logic [7:0] tf_count;
  logic [7:0] tf_number;
  logic [7:0] tf_cyl_lo;
  logic [7:0] tf_cyl_hi;
  logic [7:0] tf_status;
  logic [15:0] ext_status;
  logic [63:0] cur_lba;
  logic [15:0] status_flags;

  modport dev (
    input cmd_valid, cmd_kind, key_valid, key_word, data_valid, data_word,
    output data_ready, done, tf_error, tf_count, tf_number, tf_cyl_lo, tf_cyl_hi,
    output tf_status, ext_status, cur_lba, status_flags
  );
  modport host (
    output cmd_valid, cmd_kind, key_valid, key_word, data_valid, data_word,
    input data_ready, done, tf_error, tf_count, tf_number, tf_cyl_lo, tf_cyl_hi,
    input tf_status, ext_status, cur_lba, status_flags
  );
endinterface

// ==== hdl/sct_fill_engine.sv ====
// Device end: repeated-fill command engine with media write port
// Behaviour
// RL1 - Action code 0002h selects repeated fill
// RL2 - 0001h/0002h: background pattern/sector fill
// RL3 - 0101h/0102h: blocking pattern/sector fill
// RL4 - Start LBA words 5:2, count words 9:6
// RL5 - Words 11:10 carry the 32-bit pattern
// RL6 - Accept: error 00h, counts 01h/00h, status 50h
// RL7 - Write sectors ascending from start LBA
// RL8 - Zero count fills through last user LBA
// RL9 - Last user LBA from protected-area setting
// RL10 - Out-of-range start or end: error, no fill
// RL11 - Host sends fill sector when ready
// RL12 - Whole fill without error sets flag
// RL13 - Other user writes clear the flag
// RL14 - Read reallocations leave flag alone
// RL15 - Background: complete after data, keep filling
// RL16 - Non-status command aborts background fill
// RL17 - Extended status FFFFh running, 0000h done
// RL18 - Background abort 0008h, unrecoverable 0009h
// RL19 - Blocking: completion only after whole fill
// RL20 - Error: status 51h, code in count/number
// RL21 - Blocking unrecoverable error reports 0017h
// RL22 - Status response holds extended status word
// RL23 - Status response holds current LBA
// RL24 - Early stop: no more writes, flag cleared
`timescale 1ns/1ps
module sct_fill_engine
  import sct_fill_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to host
  sct_link_if.dev link,
  // Protected-area limit
  input wire logic [63:0] last_lba,
  // Media write port
  output logic media_req,
  output logic [63:0] media_lba,
  input wire logic media_ack,
  input wire logic media_err,
  input wire logic [6:0] media_idx,
  output logic [31:0] media_word,
  // Other user-sector writes
  input wire logic user_write
);
  // ==========================================================
  // State and storage
  typedef enum {ST_IDLE, ST_KEY, ST_CHECK, ST_DATA, ST_FILL} state_e;
  state_e state_q;
  logic [3:0] key_idx_q; // Next key word
  logic [15:0] action_q;
  logic [15:0] func_q;
  logic [63:0] start_q;
  logic [63:0] count_q;
  logic [31:0] pat_q;
  logic [6:0] word_idx_q; // Next sector data word
  logic [63:0] lba_q; // Sector being written
  logic [63:0] remain_q; // Sectors still to write
  logic whole_q; // This fill covers all user sectors
  logic bg_q; // Background mode
  logic flag_q; // Whole-media-written flag
  logic [15:0] ext_q;
  logic [31:0] buf_q [SECTOR_WORDS];
  logic [31:0] media_word_q;

  // ==========================================================
  // Decode and event terms
  logic func_ok, range_bad, is_sec, blk, whole_d, data_take;
  logic take_cmd, abort_bg, check_bad, start_fill, sect_ok, sect_err, fill_end, ok_ev;
  logic [64:0] end_excl, limit_excl;
  logic [63:0] count_eff;
  logic [15:0] bad_code;

  // Combinational decode of the loaded key sector and of this cycle's events
  always_comb begin
    func_ok = (action_q == ACT_WRITE_SAME) && // RL1
      (func_q == FN_BG_PAT || func_q == FN_BG_SEC || // RL2
       func_q == FN_BLK_PAT || func_q == FN_BLK_SEC); // RL3
    is_sec = func_q[FN_SEC_BIT];
    blk = func_q[FN_BLK_BIT];
    limit_excl = {1'b0, last_lba} + 65'h1; // RL9
    count_eff = (count_q == 64'h0) ? (last_lba - start_q + 64'h1) : count_q; // RL8
    end_excl = {1'b0, start_q} + {1'b0, count_q};
    range_bad = (start_q > last_lba) || (end_excl > limit_excl); // RL10
    bad_code = func_ok ? EXT_BAD_RANGE : EXT_BAD_FUNC;
    whole_d = (start_q == 64'h0) && (count_eff == limit_excl[63:0]);
    data_take = (state_q == ST_DATA) && link.data_valid;
    take_cmd = link.cmd_valid && (state_q == ST_IDLE || (state_q == ST_FILL && bg_q));
    abort_bg = take_cmd && state_q == ST_FILL && link.cmd_kind != CMD_SCT_STATUS; // RL16
    check_bad = (state_q == ST_CHECK) && (!func_ok || range_bad); // RL10
    start_fill = ((state_q == ST_CHECK) && !check_bad && !is_sec) ||
      (data_take && word_idx_q == SECTOR_LAST);
    sect_ok = (state_q == ST_FILL) && media_ack && !media_err && !abort_bg;
    sect_err = (state_q == ST_FILL) && media_ack && media_err && !abort_bg;
    fill_end = sect_ok && (remain_q == 64'h1); // RL7
    ok_ev = (start_fill && !blk) || (fill_end && !bg_q) || // RL15 RL19
      (take_cmd && link.cmd_kind != CMD_WRITE_SAME);
  end

  // ==========================================================
  // Command sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      key_idx_q <= 4'h0;
      word_idx_q <= 7'h0;
    end else begin
      case (state_q)
        ST_IDLE, ST_FILL: begin
          // A write-same restarts key capture, even over a background fill
          if (take_cmd && link.cmd_kind == CMD_WRITE_SAME) begin
            state_q <= ST_KEY;
            key_idx_q <= 4'h0;
          end else if (abort_bg || sect_err || fill_end) begin
            state_q <= ST_IDLE; // RL24
          end
        end
        ST_KEY: begin
          if (link.key_valid) begin
            key_idx_q <= key_idx_q + 4'h1;
            if (key_idx_q == KW_LAST) begin
              state_q <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          word_idx_q <= 7'h0;
          if (check_bad) begin
            state_q <= ST_IDLE; // RL10
          end else if (is_sec) begin
            state_q <= ST_DATA; // RL11
          end else begin
            state_q <= ST_FILL;
          end
        end
        ST_DATA: begin
          if (data_take) begin
            word_idx_q <= word_idx_q + 7'h1;
            if (word_idx_q == SECTOR_LAST) begin
              state_q <= ST_FILL;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Key sector capture; quadwords and the pattern arrive low word first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      action_q <= 16'h0;
      func_q <= 16'h0;
      start_q <= 64'h0;
      count_q <= 64'h0;
      pat_q <= 32'h0;
    end else if (state_q == ST_KEY && link.key_valid) begin
      if (key_idx_q == KW_ACTION) begin
        action_q <= link.key_word; // RL1
      end else if (key_idx_q == KW_FUNC) begin
        func_q <= link.key_word; // RL2 RL3
      end else if (key_idx_q < KW_COUNT) begin
        start_q <= {link.key_word, start_q[63:16]}; // RL4
      end else if (key_idx_q < KW_PAT) begin
        count_q <= {link.key_word, count_q[63:16]}; // RL4
      end else begin
        pat_q <= {link.key_word, pat_q[31:16]}; // RL5
      end
    end
  end

  // ==========================================================
  // Fill sector buffer: host sector or repeated pattern
  genvar gi;
  generate
    for (gi = 0; gi < SECTOR_WORDS; gi++) begin : g_buf
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          buf_q[gi] <= 32'h0;
        end else if (state_q == ST_CHECK && !is_sec) begin
          buf_q[gi] <= pat_q; // RL5
        end else if (data_take && word_idx_q == 7'(gi)) begin
          buf_q[gi] <= link.data_word;
        end
      end
    end
  endgenerate

  // Registered buffer read for the media side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      media_word_q <= 32'h0;
    end else begin
      media_word_q <= buf_q[media_idx];
    end
  end

  // ==========================================================
  // Sector walk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lba_q <= 64'h0;
      remain_q <= 64'h0;
      whole_q <= 1'b0;
      bg_q <= 1'b0;
    end else if (start_fill) begin
      lba_q <= start_q; // RL7
      remain_q <= count_eff; // RL8
      whole_q <= whole_d;
      bg_q <= !blk;
    end else if (sect_ok) begin
      lba_q <= lba_q + 64'h1; // RL7
      remain_q <= remain_q - 64'h1;
    end
  end

  // ==========================================================
  // Extended status and whole-media flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= EXT_OK;
    end else if (check_bad) begin
      ext_q <= bad_code;
    end else if (start_fill) begin
      ext_q <= EXT_RUNNING; // RL17 RL22
    end else if (abort_bg) begin
      ext_q <= EXT_BG_ABORT; // RL18
    end else if (sect_err) begin
      ext_q <= bg_q ? EXT_BG_UNREC : EXT_BLK_UNREC; // RL18 RL21
    end else if (fill_end) begin
      ext_q <= EXT_OK; // RL17
    end
  end

  // Set wins over every clear; read reallocations have no path here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (fill_end && whole_q) begin
      flag_q <= 1'b1; // RL12
    end else if (user_write || (start_fill && !whole_d)) begin
      flag_q <= 1'b0; // RL13 RL14
    end else if (abort_bg || sect_err) begin
      flag_q <= 1'b0; // RL24
    end
  end

  // ==========================================================
  // Completion pulse and task-file outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.done <= 1'b0;
      link.tf_error <= TF_ERR_NONE;
      {link.tf_number, link.tf_count} <= 16'h0;
      link.tf_cyl_lo <= 8'h0;
      link.tf_cyl_hi <= 8'h0;
      link.tf_status <= TF_ST_OK;
    end else begin
      link.done <= ok_ev || check_bad || (sect_err && !bg_q);
      if (check_bad || (sect_err && !bg_q)) begin
        link.tf_error <= TF_ERR_ABRT; // RL20
        {link.tf_number, link.tf_count} <= check_bad ? bad_code : EXT_BLK_UNREC; // RL21
        link.tf_status <= TF_ST_ERR;
      end else if (ok_ev) begin
        link.tf_error <= TF_ERR_NONE; // RL6
        {link.tf_number, link.tf_count} <= 16'h0;
        link.tf_cyl_lo <= TF_XFER_LO;
        link.tf_cyl_hi <= TF_XFER_HI;
        link.tf_status <= TF_ST_OK;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign media_req = (state_q == ST_FILL); // RL24
  assign media_lba = lba_q;
  assign media_word = media_word_q;
  assign link.data_ready = (state_q == ST_DATA); // RL11
  assign link.ext_status = ext_q; // RL22
  assign link.cur_lba = lba_q; // RL23
  assign link.status_flags = {15'h0, flag_q};
endmodule

// ==== hdl/sct_fill_host.sv ====
// Host end: APB-programmed fill command issuer
`timescale 1ns/1ps
module sct_fill_host
  import sct_fill_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to device
  sct_link_if.host link
);
  // ==========================================================
  // Registers and sequencer state
  typedef enum {HS_IDLE, HS_CMD, HS_KEY, HS_WAIT} hstate_e;
  hstate_e state_q;
  logic [15:0] func_q;
  logic [63:0] start_q;
  logic [63:0] count_q;
  logic [31:0] pat_q;
  cmd_kind_e kind_q;
  logic busy_q;
  logic [3:0] key_idx_q;
  logic cmd_valid_q, key_valid_q;
  logic [15:0] key_word_q;
  logic [31:0] tf_q; // Error, count, number, status as latched at done
  logic access, wr, data_wr, go, mapped;
  logic [15:0] key_d;
  logic [191:0] key_vec; // Key words 11..0

  // Access decode and key word selection
  always_comb begin
    access = psel && penable;
    wr = access && pwrite;
    data_wr = wr && (paddr == REG_DATA);
    go = wr && (paddr == REG_CTRL) && pwdata[CTRL_GO_BIT] && !busy_q;
    mapped = (paddr <= REG_LBA_HI) && (paddr[1:0] == 2'b00);
    key_vec = {pat_q, count_q, start_q, func_q, ACT_WRITE_SAME}; // Low word first
    key_d = key_vec[16 * key_idx_q +: 16];
  end

  // ==========================================================
  // Software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_q <= 16'h0;
      start_q <= 64'h0;
      count_q <= 64'h0;
      pat_q <= 32'h0;
      kind_q <= CMD_WRITE_SAME;
    end else if (wr && !busy_q) begin
      case (paddr)
        REG_CTRL: kind_q <= cmd_kind_e'(pwdata[CTRL_KIND_LSB +: 2]);
        REG_FUNC: func_q <= pwdata[15:0];
        REG_START_LO: start_q[31:0] <= pwdata;
        REG_START_HI: start_q[63:32] <= pwdata;
        REG_COUNT_LO: count_q[31:0] <= pwdata;
        REG_COUNT_HI: count_q[63:32] <= pwdata;
        REG_PATTERN: pat_q <= pwdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Command sequencer: command strobe, twelve key words for a write-same, wait for done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= HS_IDLE;
      busy_q <= 1'b0;
      key_idx_q <= 4'h0;
      cmd_valid_q <= 1'b0;
      key_valid_q <= 1'b0;
      key_word_q <= 16'h0;
    end else begin
      cmd_valid_q <= 1'b0;
      key_valid_q <= 1'b0;
      case (state_q)
        HS_IDLE: begin
          if (go) begin
            busy_q <= 1'b1;
            state_q <= HS_CMD;
          end
        end
        HS_CMD: begin
          cmd_valid_q <= 1'b1;
          key_idx_q <= 4'h0;
          state_q <= (kind_q == CMD_WRITE_SAME) ? HS_KEY : HS_WAIT;
        end
        HS_KEY: begin
          key_valid_q <= 1'b1;
          key_word_q <= key_d;
          key_idx_q <= key_idx_q + 4'h1;
          if (key_idx_q == KW_LAST) begin
            state_q <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (link.done) begin
            busy_q <= 1'b0;
            state_q <= HS_IDLE;
          end
        end
        default: state_q <= HS_IDLE;
      endcase
    end
  end

  // Task-file snapshot at each completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tf_q <= 32'h0;
    end else if (link.done) begin
      tf_q <= {link.tf_error, link.tf_count, link.tf_number, link.tf_status};
    end
  end

  // ==========================================================
  // Read mux; data writes stall until the device takes the word
  always_comb begin
    case (paddr)
      REG_CTRL: prdata = {29'h0, kind_q, 1'b0};
      REG_FUNC: prdata = {16'h0, func_q};
      REG_START_LO: prdata = start_q[31:0];
      REG_START_HI: prdata = start_q[63:32];
      REG_COUNT_LO: prdata = count_q[31:0];
      REG_COUNT_HI: prdata = count_q[63:32];
      REG_PATTERN: prdata = pat_q;
      REG_STATUS: prdata = {29'h0, link.status_flags[FLAG_WHOLE_BIT], link.data_ready, busy_q};
      REG_TF: prdata = tf_q;
      REG_EXT: prdata = {16'h0, link.ext_status};
      REG_LBA_LO: prdata = link.cur_lba[31:0];
      REG_LBA_HI: prdata = link.cur_lba[63:32];
      default: prdata = 32'h0;
    endcase
  end

  assign pready = !data_wr || link.data_ready;
  assign pslverr = access && !mapped;
  assign link.cmd_valid = cmd_valid_q;
  assign link.cmd_kind = kind_q;
  assign link.key_valid = key_valid_q;
  assign link.key_word = key_word_q;
  assign link.data_valid = data_wr;
  assign link.data_word = pwdata;
endmodule

// ==== tb/sct_fill_link_asserts.sv ====
// Link checker for fill engine and host
`timescale 1ns/1ps
module sct_fill_link_asserts
  import sct_fill_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Host to device
  input wire logic cmd_valid,
  input wire cmd_kind_e cmd_kind,
  input wire logic key_valid,
  input wire logic [15:0] key_word,
  // Device to host
  input wire logic done,
  input wire logic [7:0] tf_error,
  input wire logic [7:0] tf_count,
  input wire logic [7:0] tf_number,
  input wire logic [7:0] tf_cyl_lo,
  input wire logic [7:0] tf_cyl_hi,
  input wire logic [7:0] tf_status,
  input wire logic [15:0] ext_status,
  input wire logic [15:0] status_flags
);
  // ==========================================================
  // Command framing
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ws_cmd;
    cmd_valid && cmd_kind == CMD_WRITE_SAME;
  endsequence
  sequence s_key_burst;
    key_valid [*8];
  endsequence
  a_key_burst: assert property (s_ws_cmd |=> s_key_burst)
    else $error("key burst broken");
  a_key_action: assert property (s_ws_cmd |=> key_word == ACT_WRITE_SAME)
    else $error("bad action word");
  // ==========================================================
  // Completion answers
  a_done_single: assert property (done |=> !done)
    else $error("done too long");
  a_accept_tf: assert property (done && ext_status == EXT_RUNNING && !$past(cmd_valid) |->
    tf_status == TF_ST_OK && tf_error == TF_ERR_NONE && tf_cyl_lo == TF_XFER_LO &&
    tf_cyl_hi == TF_XFER_HI) else $error("accept tf");
  a_error_tf: assert property (done && tf_status == TF_ST_ERR |->
    tf_error == TF_ERR_ABRT && {tf_number, tf_count} == ext_status)
    else $error("error tf");
  a_other_done: assert property (cmd_valid && cmd_kind != CMD_WRITE_SAME |=> done)
    else $error("no done");
  // ==========================================================
  // Background fill status
  a_abort_code: assert property (cmd_valid && cmd_kind == CMD_OTHER &&
    ext_status == EXT_RUNNING |=> ##[0:1] ext_status == EXT_BG_ABORT)
    else $error("no abort code");
  a_status_keep: assert property (cmd_valid && cmd_kind == CMD_SCT_STATUS &&
    ext_status == EXT_RUNNING |=> ext_status != EXT_BG_ABORT)
    else $error("status aborted");
  a_flag_on_ok: assert property ($rose(status_flags[FLAG_WHOLE_BIT]) |->
    ext_status == EXT_OK) else $error("early flag");
endmodule

// ==== tb/sct_repeat_fill_command_engine_tb_top.sv ====
// Testbench for the fill engine and its host
`timescale 1ns/1ps
module sct_repeat_fill_command_engine_tb_top;
  import sct_fill_pkg::*;
  // APB and clocking
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, slv;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, pat, sec [128];
  // Media stand-in and limits
  logic [63:0] last_lba = 64'h1f, media_lba, exp_lba, st, cnt;
  logic media_req, media_ack = 0, media_err = 0, user_write = 0, slow = 0, use_sec = 0;
  logic req_h = 0;
  logic [6:0] media_idx = '0, idx1 = '0;
  logic [31:0] media_word;
  int err_total = 0, tests_run = 0, nsec = 0, err_at = -1;
  logic [15:0] fns [4] = '{FN_BG_PAT, FN_BG_SEC, FN_BLK_PAT, FN_BLK_SEC};
  logic [15:0] e_fn [5] = '{FN_BLK_PAT, FN_BG_PAT, 16'h0005, FN_BLK_PAT, FN_BG_PAT};
  logic [15:0] e_ext [5] = '{EXT_BAD_RANGE, EXT_BAD_RANGE, EXT_BAD_FUNC, EXT_BLK_UNREC,
    EXT_BG_UNREC};
  logic [63:0] e_st [5] = '{64'd32, 64'd28, 64'd0, 64'd0, 64'd0};
  int e_at [5] = '{-1, -1, -1, 2, 2};
  sct_link_if link (.pclk(pclk), .presetn(presetn));
  sct_fill_engine i_sct_fill_engine (.pclk(pclk), .presetn(presetn), .link(link),
    .last_lba(last_lba), .media_req(media_req), .media_lba(media_lba), .media_ack(media_ack),
    .media_err(media_err), .media_idx(media_idx), .media_word(media_word),
    .user_write(user_write));
  sct_fill_host i_sct_fill_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  sct_fill_link_asserts i_sct_fill_link_asserts (.pclk(pclk), .presetn(presetn),
    .cmd_valid(link.cmd_valid), .cmd_kind(link.cmd_kind), .key_valid(link.key_valid),
    .key_word(link.key_word), .done(link.done), .tf_error(link.tf_error),
    .tf_count(link.tf_count), .tf_number(link.tf_number), .tf_cyl_lo(link.tf_cyl_lo),
    .tf_cyl_hi(link.tf_cyl_hi), .tf_status(link.tf_status), .ext_status(link.ext_status),
    .status_flags(link.status_flags));
  // Free-running clock
  initial forever #4 pclk = ~pclk;
  // ==========================================================
  // Checking and bus tasks
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // Expected error answer on the task file
  function automatic logic [31:0] tf_err(input logic [15:0] e);
    return {TF_ERR_ABRT, e[7:0], e[15:8], TF_ST_ERR};
  endfunction
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      err_total++;
      report_and_stop();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Re-read a register while its masked value equals v
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, '0);
      n++;
    end while ((rd & m) === v && n < 3000);
    if (n >= 3000) begin
      err_total++;
      report_and_stop();
    end
  endtask
  // Program and start one fill, sending the sector if asked
  task automatic fill(input logic [15:0] fn, input logic [63:0] s, input logic [63:0] c);
    apb(1'b1, REG_FUNC, {16'h0, fn});
    apb(1'b1, REG_START_LO, s[31:0]);
    apb(1'b1, REG_START_HI, s[63:32]);
    apb(1'b1, REG_COUNT_LO, c[31:0]);
    apb(1'b1, REG_COUNT_HI, c[63:32]);
    apb(1'b1, REG_PATTERN, pat);
    exp_lba = s;
    nsec = 0;
    use_sec = fn[FN_SEC_BIT];
    apb(1'b1, REG_CTRL, 32'h1);
    if (use_sec) for (int i = 0; i < SECTOR_WORDS; i++) apb(1'b1, REG_DATA, sec[i]);
    poll(REG_STATUS, 32'h1, 32'h1);
  endtask
  // Media stand-in: random acks, order and data checks
  always @(posedge pclk) begin
    req_h <= media_req;
    idx1 <= media_idx;
    media_idx <= 7'($urandom());
    media_ack <= 1'b0;
    media_err <= 1'b0;
    if (req_h && media_req) chk(media_word, use_sec ? sec[idx1] : pat, "media word");
    if (media_req && !media_ack && !slow && $urandom_range(3) == 0) begin
      media_ack <= 1'b1;
      media_err <= (nsec == err_at);
      chk(media_lba, exp_lba, "media lba");
      exp_lba = exp_lba + 1;
      nsec = nsec + 1;
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h5265efe2));
    pat = $urandom();
    foreach (sec[i]) sec[i] = $urandom();
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_TF, '0);
    chk(rd, 32'h0, "tf after reset");
    apb(1'b0, 8'h34, '0);
    chk({rd, slv}, 33'h1, "unmapped read");
    foreach (fns[i]) begin
      st = $urandom_range(20);
      cnt = $urandom_range(8, 1);
      pat = $urandom();
      fill(fns[i], st, cnt);
      apb(1'b0, REG_TF, '0);
      chk(rd & 32'hff0000ff, 32'h50, "accept tf");
      poll(REG_EXT, 32'hffff, 32'hffff);
      chk(rd, EXT_OK, "fill ext");
      chk(nsec, cnt, "sector total");
    end
    fill(FN_BG_PAT, 64'd5, 64'd0);
    poll(REG_EXT, 32'hffff, 32'hffff);
    chk(nsec, 27, "fill to last lba");
    for (int r = 0; r < 2; r++) begin
      fill(FN_BLK_PAT, 64'd0, 64'd0);
      apb(1'b0, REG_STATUS, '0);
      chk({rd[2], 32'(nsec)}, {1'b1, 32'd32}, "whole flag set");
      if (r == 0) begin
        user_write <= 1'b1;
        @(posedge pclk);
        user_write <= 1'b0;
        apb(1'b0, REG_STATUS, '0);
        chk(rd[2], 1'b0, "flag cleared by write");
      end
    end
    // Stalled background fill, status request, then abort
    slow <= 1'b1;
    fill(FN_BG_PAT, 64'd3, 64'd0);
    apb(1'b0, REG_LBA_LO, '0);
    chk(rd, 32'd3, "current lba");
    apb(1'b1, REG_CTRL, 32'h3);
    poll(REG_STATUS, 32'h1, 32'h1);
    apb(1'b0, REG_EXT, '0);
    chk(rd, EXT_RUNNING, "status keeps fill");
    apb(1'b1, REG_CTRL, 32'h5);
    poll(REG_STATUS, 32'h1, 32'h1);
    apb(1'b0, REG_EXT, '0);
    chk(rd, EXT_BG_ABORT, "abort code");
    apb(1'b0, REG_STATUS, '0);
    chk({rd[2], 32'(nsec)}, 33'h0, "abort leaves flag and writes");
    slow <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      err_at = e_at[i];
      fill(e_fn[i], e_st[i], 64'd8);
      poll(REG_EXT, 32'hffff, 32'hffff);
      chk(rd, e_ext[i], "error code");
      chk(nsec, e_at[i] + 1, "sectors before stop");
      apb(1'b0, REG_TF, '0);
      if (e_ext[i] != EXT_BG_UNREC) chk(rd, tf_err(e_ext[i]), "error tf");
    end
    report_and_stop();
  end
endmodule
